// File: inc/serph_pkg.sv
// constants, opcodes, status layout and states of the serial eeprom front end
// Contract
// - status write changes only status bits 2, 3, 4, 6 and 7
// - status write refused while protect pin low and pin-enable bit set
// - protect pin falling during status write frame aborts that write
// - once the status write cycle runs, the protect pin no longer matters
// - with pin-enable bit clear the protect pin is ignored entirely
// - read: opcode, 16 address bits, then addressed byte shifts out at once
// - reading on, the address steps by one and the next byte follows
// - read address wraps from the top of the array to zero, endlessly
// - host ends a read by raising select; device stops the read
// - status read answers right after the opcode, even during a write cycle
// - with page select set, address bits 4..0 pick identification byte, incrementing
// - during hold data out floats and data in is ignored
// - after power-up the device is idle with writes disabled
// - after power-up select must fall before any instruction is taken; a select held low through reset is taken as a fall
// - each finished byte or status write clears the write-enable latch
// - internal write starts only on select rising after the exact clock count
// - during a write cycle array commands are ignored, programming goes on
// - unknown opcode does nothing and leaves data out floating
// - each byte stored with check bits; a single flipped bit is corrected
// - ready bit reads 1 during a write cycle, 0 otherwise, read only
// - write-enable command sets the latch, write-disable command clears it
// - page select bit is volatile and clears after the read or write using it
package serph_pkg;
	localparam int CLK_NS = 100;
	localparam int TWR_NS = 4000;
	localparam int TWR_CYC = (TWR_NS + CLK_NS - 1) / CLK_NS;
	localparam int ID_DEPTH = 32;
	localparam int CW = 12;

	// instruction codes, plain defaults
	localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
	localparam logic [7:0] OP_STATUS_READ_CMD = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_WRITE = 8'h02;

	// frame lengths in serial clocks
	localparam logic [5:0] CNT_OPC = 6'h08;
	localparam logic [5:0] CNT_SRW = 6'h10;
	localparam logic [5:0] CNT_ADR = 6'h18;
	localparam logic [5:0] CNT_BYW = 6'h20;

	// status bit positions
	localparam int SB_RDY = 0;
	localparam int SB_WEL = 1;
	localparam int SB_BP0 = 2;
	localparam int SB_BP1 = 3;
	localparam int SB_LIP = 4;
	localparam int SB_IPL = 6;
	localparam int SB_PROTECT_PIN_ENABLE_BIT = 7;
	localparam logic [7:0] SR_WR_MASK = 8'hdc;
	localparam logic [7:0] SR_PAIR_MASK = 8'h50;
	localparam logic [7:0] SR_RESET = 8'h00;

	// synchroniser reset levels: {wp_n, hold_n, si, sck, cs_n} and {wp, sck, cs}
	localparam logic [4:0] PIN_RESET = 5'h19;
	localparam logic [2:0] DLY_RESET = 3'h5;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD = 3'b001,
		ST_ADDR = 3'b010,
		ST_WDATA = 3'b011,
		ST_READ = 3'b100,
		ST_STAT = 3'b101,
		ST_WAITCS = 3'b110,
		ST_IGNORE = 3'b111
	} serph_state_t;
endpackage : serph_pkg

// File: src/serph_ecc.sv
// single-error-correcting code for one stored byte
`timescale 1ns/100ps
`default_nettype none
module serph_ecc
(
	input wire logic [7:0] enc_data,
	output logic [11:0] enc_code,
	input wire logic [11:0] dec_code,
	output logic [7:0] dec_data
)
;
	// hamming positions of the data bits within the 12-bit word
	localparam logic [3:0] POS [8] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc};
	logic [3:0] syn;

	function automatic logic [3:0] serph_par(input logic [7:0] d);
		serph_par[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
		serph_par[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
		serph_par[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
		serph_par[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
	endfunction : serph_par

	assign enc_code = {enc_data, serph_par(enc_data)};
	// syndrome names the failing position; parity-only errors fix nothing
	assign syn = serph_par(dec_code[11:4]) ^ dec_code[3:0];

	for (genvar i = 0; i < 8; i++)
	begin : g_fix
		assign dec_data[i] = dec_code[4 + i] ^ (syn == POS[i]);
	end
endmodule : serph_ecc
`default_nettype wire

// File: src/serph_buf.sv
// small valid/ready buffer with flush
`timescale 1ns/100ps
`default_nettype none
module serph_buf
#(
	parameter int W = 8,
	parameter int D = 2
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] slot_r [D];
	logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [PW:0] cnt_r, cnt_nxt;
	logic push, pop;

	function automatic logic [PW-1:0] serph_step(input logic [PW-1:0] p);
		serph_step = (p == PW'(D - 1)) ? '0 : PW'(p + 1'b1);
	endfunction : serph_step

	assign in_ready = cnt_r != (PW + 1)'(D);
	assign out_valid = cnt_r != '0;
	assign out_data = slot_r[rd_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// pointer and fill bookkeeping; flush drops everything
	always_comb
	begin
		wr_nxt = push ? serph_step(wr_r) : wr_r;
		rd_nxt = pop ? serph_step(rd_r) : rd_r;
		cnt_nxt = (PW + 1)'(cnt_r + push - pop);
		if (flush)
		begin
			wr_nxt = '0;
			rd_nxt = '0;
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// storage, no reset needed
	always_ff @(posedge clk)
	begin
		if (push && !flush)
			slot_r[wr_r] <= in_data;
	end
endmodule : serph_buf
`default_nettype wire

// File: src/serph_top.sv
// serial eeprom front end: pin sampling, command decode, status, read and write cycle
`timescale 1ns/100ps
`default_nettype none
module serph_top
#(
	parameter int AW = 13,
	parameter int TWR_CYC = serph_pkg::TWR_CYC
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic hold_n,
	input wire logic wp_n,
	output logic so,
	output logic so_oe,
	output logic write_busy
);
	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; sck is sampled, its edges found here
	logic [4:0] pin_meta_r, pin_sync_r;
	logic [2:0] pin_dly_r;
	logic cs_s, sck_s, si_s, hold_s, wp_s;
	logic sck_rise, sck_fall, cs_fall, cs_rise;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pin_meta_r <= serph_pkg::PIN_RESET;
			pin_sync_r <= serph_pkg::PIN_RESET;
			pin_dly_r <= serph_pkg::DLY_RESET;
		end
		else
		begin
			pin_meta_r <= {wp_n, hold_n, si, sck, cs_n};
			pin_sync_r <= pin_meta_r;
			pin_dly_r <= {pin_sync_r[4], pin_sync_r[1], pin_sync_r[0]};
		end
	end

	assign {wp_s, hold_s, si_s, sck_s, cs_s} = pin_sync_r;
	assign sck_rise = sck_s & ~pin_dly_r[1] & ~cs_s & hold_s;
	assign sck_fall = ~sck_s & pin_dly_r[1] & ~cs_s & hold_s;
	assign cs_fall = ~cs_s & pin_dly_r[0];
	assign cs_rise = cs_s & ~pin_dly_r[0];

	////////////////////////////////////////////////////////////////////////////
	// protocol state
	serph_pkg::serph_state_t st_r, st_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic [7:0] sh_in_r, sh_in_nxt, op_r, op_nxt, out_sh_r, out_sh_nxt;
	logic [15:0] addr_r, addr_nxt;
	logic [7:0] sr_r, sr_nxt, wdata_r, wdata_nxt;
	logic [AW-1:0] rd_addr_r, rd_addr_nxt, waddr_r, waddr_nxt;
	logic [2:0] obit_r, obit_nxt;
	logic [15:0] bcnt_r, bcnt_nxt;
	logic abort_r, abort_nxt, busy_r, busy_nxt, is_sr_r, is_sr_nxt, is_id_r, is_id_nxt;
	logic fetch_r, fetch_nxt, need_r, need_nxt, drv_r, drv_nxt;
	logic so_r, so_nxt, so_oe_r, so_oe_nxt;
	logic [7:0] status, opc, sr_m;
	logic flush, bo_valid, bo_ready, bi_ready, wr_fire, wr_block;
	logic [7:0] bo_data, rd_data, enc_in;
	logic [11:0] rd_code, wr_code;
	logic [11:0] mem_r [2**AW];
	logic [11:0] ident_r [serph_pkg::ID_DEPTH];

	// block protect: none, top quarter, top half, everything
	function automatic logic serph_prot(input logic [1:0] bp, input logic [AW-1:0] a);
		unique case (bp)
			2'b00: serph_prot = 1'b0;
			2'b01: serph_prot = &a[AW-1:AW-2];
			2'b10: serph_prot = a[AW-1];
			2'b11: serph_prot = 1'b1;
		endcase
	endfunction : serph_prot

	assign status = sr_r | {7'h00, busy_r};
	assign opc = {sh_in_r[6:0], si_s};
	assign bo_ready = need_r & (st_r == serph_pkg::ST_READ);
	assign rd_code = sr_r[serph_pkg::SB_IPL] ? ident_r[rd_addr_r[4:0]] : mem_r[rd_addr_r];
	assign enc_in = wdata_r;
	// identification page refuses when locked or fully protected
	assign wr_block = sr_r[serph_pkg::SB_IPL]
		? (sr_r[serph_pkg::SB_LIP] | (&sr_r[serph_pkg::SB_BP1:serph_pkg::SB_BP0]))
		: serph_prot(sr_r[serph_pkg::SB_BP1:serph_pkg::SB_BP0], AW'(addr_r));
	assign wr_fire = busy_r & (bcnt_r == '0) & ~is_sr_r;

	serph_ecc u_ecc
	(
		.enc_data(enc_in),
		.enc_code(wr_code),
		.dec_code(rd_code),
		.dec_data(rd_data)
	);

	// prefetch buffer: fetch runs ahead, shifter stalls it until a byte is used
	serph_buf #(.W(8), .D(2)) u_buf
	(
		.clk(ref_clk),
		.rst(rst),
		.flush(flush),
		.in_valid(fetch_r),
		.in_ready(bi_ready),
		.in_data(rd_data),
		.out_valid(bo_valid),
		.out_ready(bo_ready),
		.out_data(bo_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// next-state logic of the whole frame and write cycle
	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_in_nxt = sh_in_r;
		op_nxt = op_r;
		addr_nxt = addr_r;
		sr_nxt = sr_r;
		wdata_nxt = wdata_r;
		rd_addr_nxt = rd_addr_r;
		waddr_nxt = waddr_r;
		obit_nxt = obit_r;
		bcnt_nxt = bcnt_r;
		abort_nxt = abort_r;
		busy_nxt = busy_r;
		is_sr_nxt = is_sr_r;
		is_id_nxt = is_id_r;
		fetch_nxt = fetch_r;
		need_nxt = need_r;
		drv_nxt = drv_r;
		out_sh_nxt = out_sh_r;
		so_nxt = so_r;
		flush = 1'b0;
		sr_m = serph_pkg::SR_WR_MASK;

		// serial input: every sampled bit counts, held at saturation
		if (sck_rise && st_r != serph_pkg::ST_IDLE)
		begin
			sh_in_nxt = opc;
			cnt_nxt = (&cnt_r) ? cnt_r : 6'(cnt_r + 1'b1);
			unique case (st_r)
				serph_pkg::ST_CMD:
				begin
					if (cnt_r == serph_pkg::CNT_OPC - 1'b1)
					begin
						op_nxt = opc;
						if (opc == serph_pkg::OP_STATUS_READ_CMD)
						begin
							st_nxt = serph_pkg::ST_STAT;
							out_sh_nxt = status;
							obit_nxt = '0;
							need_nxt = 1'b0;
						end
						else if (busy_r)
							st_nxt = serph_pkg::ST_IGNORE;
						else if (opc == serph_pkg::OP_WRITE_ENABLE_CMD || opc == serph_pkg::OP_WRITE_DISABLE_CMD)
							st_nxt = serph_pkg::ST_WAITCS;
						else if (opc == serph_pkg::OP_READ || opc == serph_pkg::OP_WRITE)
							st_nxt = serph_pkg::ST_ADDR;
						else if (opc == serph_pkg::OP_STATUS_WRITE_CMD)
						begin
							st_nxt = serph_pkg::ST_WDATA;
							// pin only counts with enable bit
							abort_nxt = ~sr_r[serph_pkg::SB_WEL]
								| (sr_r[serph_pkg::SB_PROTECT_PIN_ENABLE_BIT] & ~wp_s);
						end
						else
							st_nxt = serph_pkg::ST_IGNORE;
					end
				end
				serph_pkg::ST_ADDR:
				begin
					addr_nxt = {addr_r[14:0], si_s};
					if (cnt_r == serph_pkg::CNT_ADR - 1'b1)
					begin
						if (op_r == serph_pkg::OP_READ)
						begin
							// start fetch after last address bit
							st_nxt = serph_pkg::ST_READ;
							rd_addr_nxt = AW'({addr_r[14:0], si_s});
							fetch_nxt = 1'b1;
							need_nxt = 1'b1;
							obit_nxt = '0;
							flush = 1'b1;
						end
						else
							st_nxt = serph_pkg::ST_WDATA;
					end
				end
				serph_pkg::ST_IDLE, serph_pkg::ST_WDATA, serph_pkg::ST_READ,
				serph_pkg::ST_STAT, serph_pkg::ST_WAITCS, serph_pkg::ST_IGNORE:
				begin
				end
			endcase
		end

		// pin fall aborts pending status write
		if (st_r == serph_pkg::ST_WDATA && op_r == serph_pkg::OP_STATUS_WRITE_CMD
			&& sr_r[serph_pkg::SB_PROTECT_PIN_ENABLE_BIT] && !wp_s)
			abort_nxt = 1'b1;

		if (fetch_r && bi_ready && !flush)
			rd_addr_nxt = AW'(rd_addr_r + 1'b1);

		// serial output: reload at byte boundary, shift on falling clock
		if (bo_ready && bo_valid)
		begin
			out_sh_nxt = bo_data;
			need_nxt = 1'b0;
		end
		if ((st_r == serph_pkg::ST_READ || st_r == serph_pkg::ST_STAT) && sck_fall && !need_r)
		begin
			so_nxt = out_sh_r[7];
			drv_nxt = 1'b1;
			out_sh_nxt = {out_sh_r[6:0], 1'b0};
			obit_nxt = 3'(obit_r + 1'b1);
			if (&obit_r)
			begin
				if (st_r == serph_pkg::ST_STAT)
					out_sh_nxt = status;
				else
					need_nxt = 1'b1;
			end
		end

		// internal write cycle; the protect pin plays no part once running
		if (busy_r)
		begin
			if (bcnt_r == '0)
			begin
				busy_nxt = 1'b0;
				if (is_sr_r)
				begin
					// both lock and select at once leave those two alone
					if ((wdata_r & serph_pkg::SR_PAIR_MASK) == serph_pkg::SR_PAIR_MASK)
						sr_m = serph_pkg::SR_WR_MASK & ~serph_pkg::SR_PAIR_MASK;
					sr_nxt = (sr_r & ~sr_m) | (wdata_r & sr_m);
				end
				if (is_id_r)
					sr_nxt[serph_pkg::SB_IPL] = 1'b0;
				sr_nxt[serph_pkg::SB_WEL] = 1'b0;
			end
			else
				bcnt_nxt = 16'(bcnt_r - 1'b1);
		end

		// select edges end or open a frame
		if (cs_fall)
		begin
			st_nxt = serph_pkg::ST_CMD;
			cnt_nxt = '0;
			abort_nxt = 1'b0;
		end
		else if (cs_rise)
		begin
			st_nxt = serph_pkg::ST_IDLE;
			drv_nxt = 1'b0;
			fetch_nxt = 1'b0;
			need_nxt = 1'b0;
			flush = 1'b1;
			if (st_r == serph_pkg::ST_READ)
				sr_nxt[serph_pkg::SB_IPL] = 1'b0;
			if (st_r == serph_pkg::ST_WAITCS && cnt_r == serph_pkg::CNT_OPC)
				sr_nxt[serph_pkg::SB_WEL] = (op_r == serph_pkg::OP_WRITE_ENABLE_CMD);
			if (st_r == serph_pkg::ST_WDATA && !busy_r)
			begin
				if (op_r == serph_pkg::OP_STATUS_WRITE_CMD && cnt_r == serph_pkg::CNT_SRW && !abort_r)
				begin
					busy_nxt = 1'b1;
					is_sr_nxt = 1'b1;
					is_id_nxt = 1'b0;
					wdata_nxt = sh_in_r;
					bcnt_nxt = 16'(TWR_CYC - 1);
				end
				else if (op_r == serph_pkg::OP_WRITE && cnt_r == serph_pkg::CNT_BYW
					&& sr_r[serph_pkg::SB_WEL] && !wr_block)
				begin
					busy_nxt = 1'b1;
					is_sr_nxt = 1'b0;
					is_id_nxt = sr_r[serph_pkg::SB_IPL];
					wdata_nxt = sh_in_r;
					waddr_nxt = AW'(addr_r);
					bcnt_nxt = 16'(TWR_CYC - 1);
				end
			end
		end

		so_oe_nxt = drv_nxt & hold_s & ~cs_s;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			st_r <= serph_pkg::ST_IDLE;
			cnt_r <= '0;
			sh_in_r <= '0;
			op_r <= '0;
			addr_r <= '0;
			sr_r <= serph_pkg::SR_RESET;
			wdata_r <= '0;
			rd_addr_r <= '0;
			waddr_r <= '0;
			obit_r <= '0;
			bcnt_r <= '0;
			abort_r <= 1'b0;
			busy_r <= 1'b0;
			is_sr_r <= 1'b0;
			is_id_r <= 1'b0;
			fetch_r <= 1'b0;
			need_r <= 1'b0;
			drv_r <= 1'b0;
			out_sh_r <= '0;
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_in_r <= sh_in_nxt;
			op_r <= op_nxt;
			addr_r <= addr_nxt;
			sr_r <= sr_nxt;
			wdata_r <= wdata_nxt;
			rd_addr_r <= rd_addr_nxt;
			waddr_r <= waddr_nxt;
			obit_r <= obit_nxt;
			bcnt_r <= bcnt_nxt;
			abort_r <= abort_nxt;
			busy_r <= busy_nxt;
			is_sr_r <= is_sr_nxt;
			is_id_r <= is_id_nxt;
			fetch_r <= fetch_nxt;
			need_r <= need_nxt;
			drv_r <= drv_nxt;
			out_sh_r <= out_sh_nxt;
			so_r <= so_nxt;
			so_oe_r <= so_oe_nxt;
		end
	end

	// coded storage written at cycle end
	always_ff @(posedge ref_clk)
	begin
		if (wr_fire && is_id_r)
			ident_r[waddr_r[4:0]] <= wr_code;
		else if (wr_fire)
			mem_r[waddr_r] <= wr_code;
	end

	assign so = so_r;
	assign so_oe = so_oe_r;
	assign write_busy = busy_r;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	sequence s_sr_done;
		busy_r && bcnt_r == '0 && is_sr_r;
	endsequence
	sequence s_opc_in;
		st_r == serph_pkg::ST_CMD && sck_rise && cnt_r == 6'h07;
	endsequence

	property p_sr_mask;
		s_sr_done |=> !sr_r[5] && !sr_r[serph_pkg::SB_WEL];
	endproperty
	a_sr_mask: assert property (p_sr_mask) else $error("status write touched fixed bits");
	property p_sr_refuse;
		st_r == serph_pkg::ST_WDATA && op_r == serph_pkg::OP_STATUS_WRITE_CMD && abort_r && cs_rise
			|=> !busy_r;
	endproperty
	a_sr_refuse: assert property (p_sr_refuse) else $error("refused status write started");
	property p_wp_abort;
		st_r == serph_pkg::ST_WDATA && op_r == serph_pkg::OP_STATUS_WRITE_CMD
			&& sr_r[serph_pkg::SB_PROTECT_PIN_ENABLE_BIT] && !wp_s |=> abort_r;
	endproperty
	a_wp_abort: assert property (p_wp_abort) else $error("pin fall did not abort");
	property p_sr_commit;
		s_sr_done |=> sr_r[3:2] == $past(wdata_r[3:2]);
	endproperty
	a_sr_commit: assert property (p_sr_commit) else $error("protect bits not written");
	property p_wp_late;
		busy_r && is_sr_r && bcnt_r != '0 && pin_dly_r[2] && !wp_s |=> busy_r;
	endproperty
	a_wp_late: assert property (p_wp_late) else $error("pin fall stopped status write");
	property p_rd_step;
		fetch_r && bi_ready && !flush |=> rd_addr_r == AW'($past(rd_addr_r) + 1'b1);
	endproperty
	a_rd_step: assert property (p_rd_step) else $error("read address did not step");
	property p_cs_stop;
		cs_rise |=> st_r == serph_pkg::ST_IDLE && !so_oe_r && !fetch_r;
	endproperty
	a_cs_stop: assert property (p_cs_stop) else $error("select rise did not stop");
	property p_stat_any;
		s_opc_in and opc == serph_pkg::OP_STATUS_READ_CMD && !cs_fall && !cs_rise
			|=> st_r == serph_pkg::ST_STAT;
	endproperty
	a_stat_any: assert property (p_stat_any) else $error("status read not taken");
	property p_hold_float;
		!hold_s |=> !so_oe_r;
	endproperty
	a_hold_float: assert property (p_hold_float) else $error("output driven in hold");
	property p_idle_wait;
		st_r == serph_pkg::ST_IDLE && !cs_fall |=> st_r == serph_pkg::ST_IDLE;
	endproperty
	a_idle_wait: assert property (p_idle_wait) else $error("left idle without select fall");
	property p_busy_ignore;
		s_opc_in and busy_r && opc != serph_pkg::OP_STATUS_READ_CMD && !cs_fall && !cs_rise
			|=> st_r == serph_pkg::ST_IGNORE;
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");
	property p_ignore_quiet;
		st_r == serph_pkg::ST_IGNORE |=> !so_oe_r;
	endproperty
	a_ignore_quiet: assert property (p_ignore_quiet) else $error("output driven on bad opcode");
	property p_wel_clear;
		$fell(busy_r) |-> !sr_r[serph_pkg::SB_WEL];
	endproperty
	a_wel_clear: assert property (p_wel_clear) else $error("latch still set after write");
endmodule : serph_top
`default_nettype wire

// File: dv/serph_host.sv
// host controller model: drives the serial pins, samples data out
`timescale 1ns/100ps
`default_nettype none
module serph_host
(
	input wire logic ref_clk,
	input wire logic so,
	input wire logic so_oe,
	output logic cs_n,
	output logic sck,
	output logic si,
	output logic hold_n,
	output logic wp_n
);
	logic oe_seen;
	////////////////////////////////////////////////////////////
	// idle pins from time zero
	initial
	begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		hold_n = 1'b1;
		wp_n = 1'b1;
	end
	// remembers any drive of data out while selected
	always @(posedge ref_clk)
		oe_seen <= cs_n ? 1'b0 : (oe_seen | (so_oe === 1'b1));
	////////////////////////////////////////////////////////////
	// pins move only just after a falling clock edge
	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : wt
	task automatic set_wp(input logic v);
		wp_n = v;
	endtask : set_wp
	task automatic open_f();
		cs_n = 1'b0;
		wt(5);
	endtask : open_f
	// data set while low, sampled at rise; 4+4 clocks make 800 ns
	task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			sck = 1'b0;
			si = tx[i];
			wt(4);
			rx[i] = (so_oe === 1'b1) ? so : 1'bx;
			sck = 1'b1;
			wt(4);
		end
	endtask : shift
	// hold moves only while the clock is low
	task automatic pause(output logic oe);
		sck = 1'b0;
		wt(4);
		hold_n = 1'b0;
		wt(6);
		oe = so_oe;
		si = ~si;
		wt(4);
		hold_n = 1'b1;
		wt(4);
	endtask : pause
	// select rises after whole bytes; released line inverted
	task automatic close_f(output logic seen);
		sck = 1'b0;
		wt(4);
		seen = oe_seen;
		cs_n = 1'b1;
		si = ~si;
		wt(6);
	endtask : close_f
endmodule : serph_host
`default_nettype wire

// File: dv/test_serph.sv
// self-checking bench for the serial eeprom front end
`timescale 1ns/100ps
`default_nettype none
module test_serph;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic cs_n, sck, si, hold_n, wp_n, so, so_oe, write_busy, seen, hoe;
	logic [7:0] st;
	logic [7:0] rx[$];
	int num_errors = 0;
	int check_count = 0;
	int cyc = 0;
	////////////////////////////////////////////////////////////
	// long write time so commands fit inside the busy window
	always #50 ref_clk = ~ref_clk;
	serph_top #(.TWR_CYC(600)) uut (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sck(sck),
		.si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .write_busy(write_busy));
	serph_host host (.ref_clk(ref_clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck),
		.si(si), .hold_n(hold_n), .wp_n(wp_n));
	////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] sv, input logic [7:0] ev);
		check_count++;
		if (sv !== ev)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, ev, sv);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	// hang guard
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 80000)
		begin
			num_errors++;
			print_verdict();
		end
	end
	// one frame of whole bytes, optional hold before byte hold_at
	task automatic frm(input logic [7:0] tx[$], input int hold_at);
		logic [7:0] r;
		rx = {};
		host.open_f();
		foreach (tx[i])
		begin
			if (i == hold_at)
				host.pause(hoe);
			host.shift(tx[i], r);
			rx.push_back(r);
		end
		host.close_f(seen);
	endtask : frm
	task automatic status_read_cmd();
		frm({serph_pkg::OP_STATUS_READ_CMD, 8'h00}, -1);
		st = rx[1];
	endtask : status_read_cmd
	task automatic wr(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d);
		frm({serph_pkg::OP_WRITE_ENABLE_CMD}, -1);
		if (op == serph_pkg::OP_WRITE)
			frm({op, a[15:8], a[7:0], d}, -1);
		else
			frm({op, d}, -1);
	endtask : wr
	// poll ready bit a bounded number of times, then read once more
	task automatic settle();
		int n;
		n = 0;
		status_read_cmd();
		while (st[0] !== 1'b0 && n < 20)
		begin
			status_read_cmd();
			n++;
		end
		status_read_cmd();
	endtask : settle
	task automatic rd2(input logic [15:0] a, input int h);
		frm({serph_pkg::OP_READ, a[15:8], a[7:0], 8'h00, 8'h00}, h);
	endtask : rd2
	////////////////////////////////////////////////////////////
	initial
	begin
		repeat (12) @(negedge ref_clk);
		rst = 1'b0;
		host.wt(4);
		status_read_cmd();
		chk("status at start", st, serph_pkg::SR_RESET);
		frm({serph_pkg::OP_WRITE_ENABLE_CMD}, -1);
		status_read_cmd();
		chk("latch set", st, 8'h02);
		frm({serph_pkg::OP_WRITE_DISABLE_CMD}, -1);
		status_read_cmd();
		chk("latch clear", st, 8'h00);
		frm({8'hff, 8'h00}, -1);
		chk("unknown op drive", {7'h00, seen}, 8'h00);
		$display("test commands done");
		wr(serph_pkg::OP_WRITE, 16'h1fff, 8'ha5);
		rd2(16'h1fff, -1);
		chk("read while busy", {7'h00, seen}, 8'h00);
		status_read_cmd();
		chk("ready bit busy", {7'h00, st[0]}, 8'h01);
		chk("busy pin", {7'h00, write_busy}, 8'h01);
		settle();
		chk("status after write", st, 8'h00);
		wr(serph_pkg::OP_WRITE, 16'h0000, 8'h3c);
		settle();
		frm({serph_pkg::OP_WRITE_ENABLE_CMD}, -1);
		frm({serph_pkg::OP_WRITE, 8'h00, 8'h00, 8'h99, 8'h99}, -1);
		settle();
		rd2(16'h1fff, 4);
		chk("first byte", rx[3], 8'ha5);
		chk("wrapped byte", rx[4], 8'h3c);
		chk("hold drive", {7'h00, hoe}, 8'h00);
		chk("drive after end", {7'h00, so_oe}, 8'h00);
		$display("test array done");
		for (int k = 0; k < 2; k++)
		begin
			wr(serph_pkg::OP_STATUS_WRITE_CMD, 16'h0000, 8'h40);
			settle();
			wr(serph_pkg::OP_WRITE, 16'(16'h0010 + k), 8'(8'h77 - 8'h22 * k));
			settle();
			chk("select after write", st, 8'h00);
		end
		wr(serph_pkg::OP_STATUS_WRITE_CMD, 16'h0000, 8'h40);
		settle();
		rd2(16'h0010, -1);
		chk("page byte", rx[3], 8'h77);
		chk("page next", rx[4], 8'h55);
		status_read_cmd();
		chk("select after read", st, 8'h00);
		$display("test page done");
		wr(serph_pkg::OP_STATUS_WRITE_CMD, 16'h0000, 8'hff);
		settle();
		chk("status mask", st, 8'h8c);
		host.set_wp(1'b0);
		wr(serph_pkg::OP_STATUS_WRITE_CMD, 16'h0000, 8'h00);
		settle();
		chk("pin protect", st & 8'hfd, 8'h8c);
		host.set_wp(1'b1);
		frm({serph_pkg::OP_WRITE_ENABLE_CMD}, -1);
		host.open_f();
		host.shift(serph_pkg::OP_STATUS_WRITE_CMD, st);
		host.set_wp(1'b0);
		host.shift(8'h00, st);
		host.close_f(seen);
		host.set_wp(1'b1);
		settle();
		chk("abort", st & 8'hfd, 8'h8c);
		wr(serph_pkg::OP_STATUS_WRITE_CMD, 16'h0000, 8'h04);
		host.set_wp(1'b0);
		settle();
		chk("late pin fall", st, 8'h04);
		wr(serph_pkg::OP_STATUS_WRITE_CMD, 16'h0000, 8'h08);
		settle();
		chk("pin ignored", st, 8'h08);
		wr(serph_pkg::OP_WRITE, 16'h1fff, 8'h11);
		wr(serph_pkg::OP_WRITE, 16'h0000, 8'h22);
		settle();
		frm({serph_pkg::OP_WRITE, 8'h00, 8'h00, 8'h33}, -1);
		rd2(16'h1fff, -1);
		chk("protected byte", rx[3], 8'ha5);
		chk("write without latch", rx[4], 8'h22);
		host.set_wp(1'b1);
		$display("test protect done");
		print_verdict();
	end
endmodule : test_serph
`default_nettype wire
